// ---- inc/bwp_pkg.sv ----
package bwp_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] PORT_ZERO_ADDR  = 8'h80;
	localparam logic [7:0] PORT_ONE_ADDR   = 8'h90;
	localparam logic [7:0] PORT_TWO_ADDR   = 8'ha0;
	localparam logic [7:0] PORT_THREE_ADDR = 8'hb0;
	localparam logic [7:0] EDGE_FLAGS_ADDR = 8'had;

	// ------------------------------------------------------------
	// Reset values and field layout
	// ------------------------------------------------------------
	localparam logic [7:0] LATCH_RESET     = 8'hff;
	localparam logic [3:0] FLAGS_RESET     = 4'h0;
	localparam logic [3:0] FLAGS_LOW_READ  = 4'h0;
	localparam int         FLAGS_LSB       = 4;
	localparam int         PORT_COUNT      = 4;
	localparam int         PORT_ONE        = 1;
	localparam logic [7:0] UNMAPPED_READ   = 8'h00;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	// One SFR access from the core; for a bit access wdata[0] is the
	// bit value and bit_sel picks the bit.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       bit_op;
		logic       rmw;
		logic [2:0] bit_sel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bwp_sfr_req_s;

	typedef struct packed {
		logic       valid;
		logic       hit;
		logic [7:0] data;
	} bwp_sfr_rsp_s;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pullup_en;
	} bwp_pin_drive_s;

endpackage

// ---- src/bwp_edge_flag.sv ----
`timescale 1ns/1ps
module bwp_edge_flag
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic pin,
	input  wire logic clr,
	output logic      pending
);

	logic prev;
	logic fall;

	assign fall = prev & ~pin;

	// ------------------------------------------------------------
	// Falling edge capture
	// ------------------------------------------------------------
	// Idle level is high, so reset to 1 avoids a false edge at start
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			prev <= 1'b1;
		else
			prev <= pin;
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pending <= 1'b0;
		else if (fall)
			pending <= 1'b1;
		else if (clr)
			pending <= 1'b0;
	end

endmodule

// ---- src/bwp_port_io.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - A written port value is latched and keeps driving pins until next write.
// - Plain reads return pin levels, whatever the routing matrix assigns.
// - Read-modify-write accesses read the latch, not pins, then write back.
// - Logic, bit-jump, complement, inc/dec and bit-destination ops are RMW.
// - Four eight-bit ports, each one register, byte and bit addressable.
// - Latch 0 drives low; 1 drives high, or floats when its mode bit is 0.
// - All port registers and edge flags work whether or not pins are bonded.
// - Weak pull-ups are enabled from reset until software disables them.
module bwp_port_io
(
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire bwp_pkg::bwp_sfr_req_s      sfr_req,
	output bwp_pkg::bwp_sfr_rsp_s           sfr_rsp,
	input  wire logic [3:0][7:0]            pin_in,
	input  wire logic [3:0][7:0]            output_mode_config,
	input  wire logic                       pullup_disable,
	output bwp_pkg::bwp_pin_drive_s [3:0]   pin_drive,
	output logic [3:0]                      edge_pending
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Port registers sit at 0x80, 0x90, 0xa0, 0xb0: high bits 10,
	// low nibble zero, index in bits 5..4
	function automatic logic is_port(input logic [7:0] a);
		is_port = (a[7:6] == 2'h2) && (a[3:0] == 4'h0);
	endfunction

	// New byte after a byte write or a single bit write
	function automatic logic [7:0] merge(input logic [7:0] old,
		input bwp_pkg::bwp_sfr_req_s r);
		logic [7:0] v;
		v = old;
		if (r.bit_op)
			v[r.bit_sel] = r.wdata[0];
		else
			v = r.wdata;
		merge = v;
	endfunction

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic [3:0][7:0] port_latch;
	logic [1:0]      port_idx;
	logic            port_hit;
	logic            flags_hit;
	logic            port_wr;
	logic            flags_wr;
	logic [7:0]      flags_next;
	logic [3:0]      flag_clr;
	logic [7:0]      read_value;
	logic [7:0]      flags_view;
	logic [7:0]      port_view;
	logic            pullup_en;

	assign port_idx  = sfr_req.addr[5:4];
	assign port_hit  = is_port(sfr_req.addr);
	assign flags_hit = sfr_req.addr == bwp_pkg::EDGE_FLAGS_ADDR;
	assign port_wr   = sfr_req.wr & port_hit;
	assign flags_wr  = sfr_req.wr & flags_hit;

	// Unused low flag bits always read back as zero
	assign flags_view = {edge_pending, bwp_pkg::FLAGS_LOW_READ};

	// RMW accesses see the latch; plain reads see the pins, which is
	// why a pin handed to another peripheral still reads true
	assign port_view = sfr_req.rmw ? port_latch[port_idx]
		: pin_in[port_idx];

	assign read_value = port_hit ? port_view
		: flags_hit ? flags_view
		: bwp_pkg::UNMAPPED_READ;

	// Only a written 0 clears a flag; writing 1 leaves it alone
	assign flags_next = merge(flags_view, sfr_req);
	assign flag_clr   = {4{flags_wr}}
		& ~flags_next[bwp_pkg::FLAGS_LSB +: 4];

	// ------------------------------------------------------------
	// Port latches
	// ------------------------------------------------------------
	// Writes go to the latch regardless of bonding, so unbonded
	// ports stay fully usable by software
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			port_latch <= {bwp_pkg::PORT_COUNT{bwp_pkg::LATCH_RESET}};
		else if (port_wr)
			port_latch[port_idx] <= merge(port_latch[port_idx],
				sfr_req);
	end

	// ------------------------------------------------------------
	// Read answer
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			sfr_rsp <= '0;
		else
		begin
			sfr_rsp.valid <= sfr_req.rd;
			sfr_rsp.hit   <= sfr_req.rd & (port_hit | flags_hit);
			sfr_rsp.data  <= sfr_req.rd ? read_value
				: bwp_pkg::UNMAPPED_READ;
		end
	end

	// ------------------------------------------------------------
	// Pull-up control
	// ------------------------------------------------------------
	// Held on through reset so nothing floats before software runs
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pullup_en <= 1'b1;
		else
			pullup_en <= ~pullup_disable;
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < bwp_pkg::PORT_COUNT; g++)
		begin : g_drive
			assign pin_drive[g].out = port_latch[g];
			assign pin_drive[g].oe  = ~port_latch[g]
				| output_mode_config[g];
			assign pin_drive[g].pullup_en = {8{pullup_en}};
		end
	endgenerate

	// ------------------------------------------------------------
	// Port one edge flags
	// ------------------------------------------------------------
	generate
		for (g = 0; g < 4; g++)
		begin : g_edge
			bwp_edge_flag u_flag
			(
				.clk     (clk),
				.sys_rst (sys_rst),
				.pin     (pin_in[bwp_pkg::PORT_ONE][bwp_pkg::FLAGS_LSB + g]),
				.clr     (flag_clr[g]),
				.pending (edge_pending[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence byte_write_s;
		sfr_req.wr && port_hit && !sfr_req.bit_op;
	endsequence

	sequence plain_read_s;
		sfr_req.rd && port_hit && !sfr_req.rmw;
	endsequence

	sequence rmw_read_s;
		sfr_req.rd && port_hit && sfr_req.rmw;
	endsequence

	sequence bit_write_s;
		sfr_req.wr && port_hit && sfr_req.bit_op;
	endsequence

	sequence stray_read_s;
		sfr_req.rd && !port_hit && !flags_hit;
	endsequence

	sequence stray_write_s;
		sfr_req.wr && !port_hit && !flags_hit;
	endsequence

	latch_holds_a: assert property (
		!port_wr |=> port_latch == $past(port_latch))
		else $error("Port latch changed without a write");

	byte_write_a: assert property (
		byte_write_s |=> port_latch[$past(port_idx)] == $past(sfr_req.wdata))
		else $error("Byte write not latched");

	bit_write_a: assert property (
		sfr_req.wr && port_hit && sfr_req.bit_op
		|=> port_latch[$past(port_idx)][$past(sfr_req.bit_sel)]
			== $past(sfr_req.wdata[0]))
		else $error("Bit write not latched");

	pin_read_a: assert property (
		plain_read_s |=> sfr_rsp.valid && sfr_rsp.hit
			&& sfr_rsp.data == $past(pin_in[port_idx]))
		else $error("Plain read did not return pins");

	rmw_read_a: assert property (
		rmw_read_s |=> sfr_rsp.data == $past(port_latch[port_idx]))
		else $error("RMW read did not return latch");

	drive_level_a: assert property (
		byte_write_s |=> pin_drive[$past(port_idx)].out == $past(sfr_req.wdata)
			&& pin_drive[$past(port_idx)].oe
			== (~$past(sfr_req.wdata) | output_mode_config[$past(port_idx)]))
		else $error("Pin drive does not follow latch and mode");

	pullup_follow_a: assert property (
		pullup_disable [*2] |=> !pin_drive[1].pullup_en[0])
		else $error("Pull-up not released on disable");

	flag_clear_a: assert property (
		flags_wr && !sfr_req.bit_op && sfr_req.wdata == 8'h00
		&& !(pin_in[1][7] == 1'b0 && $past(pin_in[1][7]))
		|=> !edge_pending[3])
		else $error("Flag not cleared by write of 0");

	flag_set_a: assert property (
		$fell(pin_in[1][4]) |=> edge_pending[0] [*1] ##1 1'b1)
		else $error("Falling edge did not set flag");

	flags_low_a: assert property (
		sfr_req.rd && flags_hit |=> sfr_rsp.data[3:0] == 4'h0)
		else $error("Unused flag bits read non-zero");

	read_valid_a: assert property (
		sfr_req.rd |=> sfr_rsp.valid)
		else $error("Read not answered in the next cycle");

	idle_answer_a: assert property (
		!sfr_req.rd |=> !sfr_rsp.valid && !sfr_rsp.hit
			&& sfr_rsp.data == bwp_pkg::UNMAPPED_READ)
		else $error("Answer shown without a read");

	read_hit_a: assert property (
		sfr_req.rd && (port_hit || flags_hit) |=> sfr_rsp.hit)
		else $error("Mapped read not marked as hit");

	stray_read_a: assert property (
		stray_read_s |=> !sfr_rsp.hit
			&& sfr_rsp.data == bwp_pkg::UNMAPPED_READ)
		else $error("Unmapped read returned data");

	stray_write_a: assert property (
		stray_write_s |=> port_latch == $past(port_latch))
		else $error("Unmapped write changed a latch");

	bit_others_a: assert property (
		bit_write_s ##0 (sfr_req.bit_sel == 3'h0)
		|=> port_latch[$past(port_idx)][7:1]
			== $past(port_latch[port_idx][7:1]))
		else $error("Bit write disturbed other bits");

	rmw_writeback_a: assert property (
		rmw_read_s ##0 (sfr_req.wr && !sfr_req.bit_op)
		|=> sfr_rsp.data == $past(port_latch[port_idx])
			&& port_latch[$past(port_idx)] == $past(sfr_req.wdata))
		else $error("RMW did not read old latch and write back");

	drive_low_a: assert property (
		byte_write_s ##0 (!sfr_req.wdata[0])
		|=> pin_drive[$past(port_idx)].oe[0]
			&& !pin_drive[$past(port_idx)].out[0])
		else $error("Written 0 does not drive low");

	open_drain_a: assert property (
		byte_write_s ##0 (sfr_req.wdata[7])
		|=> pin_drive[$past(port_idx)].oe[7]
			== output_mode_config[$past(port_idx)][7])
		else $error("Written 1 ignores the output mode");

	pullup_on_a: assert property (
		!pullup_disable |=> pin_drive[3].pullup_en == 8'hff)
		else $error("Pull-up off while enabled");

	// Reset itself must be watched here, so this one is never disabled
	reset_state_a: assert property (
		disable iff (1'b0)
		sys_rst |=> pin_drive[2].pullup_en == 8'hff
			&& pin_drive[2].out == bwp_pkg::LATCH_RESET
			&& edge_pending == bwp_pkg::FLAGS_RESET)
		else $error("Reset state not applied");

	flag_hold_a: assert property (
		edge_pending[1] && !flag_clr[1] |=> edge_pending[1])
		else $error("Pending flag lost without a clear");

	flag_quiet_a: assert property (
		!edge_pending[2] && !$fell(pin_in[1][6]) |=> !edge_pending[2])
		else $error("Flag set without a falling edge");

	flag_keep_a: assert property (
		flags_wr && !sfr_req.bit_op && sfr_req.wdata[7] && edge_pending[3]
		|=> edge_pending[3])
		else $error("Writing 1 cleared a pending flag");

	flag_read_a: assert property (
		sfr_req.rd && flags_hit |=> sfr_rsp.data[7:4] == $past(edge_pending))
		else $error("Flag read does not match pending flags");

endmodule

// ---- test/bwp_pin_model.sv ----
`timescale 1ns/1ps
module bwp_pin_model
(
	input  wire logic                          clk,
	input  wire bwp_pkg::bwp_pin_drive_s [3:0] pin_drive,
	input  wire logic [3:0][7:0]               ext_en,
	input  wire logic [3:0][7:0]               ext_val,
	output logic [3:0][7:0]                    pin_in
);
	// ------------------------------------------------------------
	// Pin level
	// ------------------------------------------------------------
	// A floating pin with no pull-up shows the inverse of its last level
	logic [3:0][7:0] last;
	always_comb
	begin
		for (int p = 0; p < 4; p++)
			for (int b = 0; b < 8; b++)
				if (ext_en[p][b])
					pin_in[p][b] = ext_val[p][b];
				else if (pin_drive[p].oe[b])
					pin_in[p][b] = pin_drive[p].out[b];
				else if (pin_drive[p].pullup_en[b])
					pin_in[p][b] = 1'b1;
				else
					pin_in[p][b] = ~last[p][b];
	end
	always_ff @(posedge clk)
		last <= pin_in;
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic                          clk;
	logic                          sys_rst;
	bwp_pkg::bwp_sfr_req_s         req;
	bwp_pkg::bwp_sfr_rsp_s         rsp;
	logic [3:0][7:0]               pin_in;
	logic [3:0][7:0]               mode;
	logic                          pullup_disable;
	bwp_pkg::bwp_pin_drive_s [3:0] drv;
	logic [3:0]                    pend;
	logic [3:0][7:0]               ext_en;
	logic [3:0][7:0]               ext_val;
	int                            num_errors;
	int                            samples_checked;
	logic [7:0]                    v [4];
	logic [7:0]                    a [4];

	bwp_port_io uut (.clk(clk), .sys_rst(sys_rst), .sfr_req(req),
		.sfr_rsp(rsp), .pin_in(pin_in), .output_mode_config(mode),
		.pullup_disable(pullup_disable), .pin_drive(drv),
		.edge_pending(pend));
	bwp_pin_model pins (.clk(clk), .pin_drive(drv), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic acc(input logic r, w, bo, m, input logic [2:0] s,
		input logic [7:0] ad, d);
		@(posedge clk);
		req <= '{rd:r, wr:w, bit_op:bo, rmw:m, bit_sel:s, addr:ad, wdata:d};
		@(posedge clk);
		req <= '0;
		#1;
	endtask
	task automatic rd(input logic [7:0] ad, input logic m,
		input logic [7:0] exp);
		acc(1'b1, 1'b0, 1'b0, m, 3'h0, ad, 8'h00);
		chk({7'h00, rsp.valid}, 8'h01);
		chk(rsp.data, exp);
	endtask
	task automatic end_sim;
		$display("Checked %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#20us;
		num_errors++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		num_errors = 0;
		samples_checked = 0;
		req = '0;
		sys_rst = 1'b1;
		mode = {8'hff, 8'hff, 8'h0f, 8'h0f};
		pullup_disable = 1'b0;
		ext_en = '0;
		ext_val = '0;
		a = '{8'h80, 8'h90, 8'ha0, 8'hb0};
		v = '{8'h5a, 8'hf0, 8'h3c, 8'hc3};
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		for (int p = 0; p < 4; p++)
		begin
			rd(a[p], 1'b1, 8'hff);
			chk(drv[p].out, 8'hff);
			chk(drv[p].pullup_en, 8'hff);
		end
		rd(8'had, 1'b0, 8'h00);
		$display("Test reset done");
		for (int p = 0; p < 4; p++)
		begin
			acc(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, a[p], v[p]);
			chk(drv[p].out, v[p]);
			chk(drv[p].oe, ~v[p] | mode[p]);
			rd(a[p], 1'b0, v[p]);
		end
		$display("Test byte writes done");
		ext_en[0] <= 8'hff;
		ext_val[0] <= 8'ha5;
		rd(8'h80, 1'b0, 8'ha5);
		rd(8'h80, 1'b1, 8'h5a);
		acc(1'b1, 1'b1, 1'b0, 1'b1, 3'h0, 8'h80, 8'h55);
		chk(rsp.data, 8'h5a);
		rd(8'h80, 1'b1, 8'h55);
		acc(1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 8'hb0, 8'h00);
		rd(8'hb0, 1'b1, 8'hc2);
		acc(1'b0, 1'b1, 1'b1, 1'b0, 3'h5, 8'hb0, 8'h01);
		rd(8'hb0, 1'b1, 8'he2);
		$display("Test latch reads done");
		ext_en <= {8'h00, 8'h00, 8'hf0, 8'h00};
		ext_val[1] <= 8'hf0;
		@(posedge clk);
		ext_val[1] <= 8'h50;
		repeat (3) @(posedge clk);
		#1;
		chk({4'h0, pend}, 8'h0a);
		rd(8'had, 1'b0, 8'ha0);
		acc(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'had, 8'h80);
		rd(8'had, 1'b0, 8'h80);
		chk({4'h0, pend}, 8'h08);
		acc(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h81, 8'h00);
		rd(8'h81, 1'b0, 8'h00);
		chk({7'h00, rsp.hit}, 8'h00);
		rd(8'h80, 1'b1, 8'h55);
		$display("Test edge flags done");
		pullup_disable <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(drv[0].pullup_en, 8'h00);
		$display("Test pull-ups done");
		end_sim();
	end
endmodule
